/* hdl/ccr_defs.svh */
// constants of the can controller control-register and reset-mode block
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
`define CCR_ADDR_CONTROL 8'h00
`define CCR_ADDR_COMMAND 8'h04
`define CCR_ADDR_STATUS 8'h08
`define CCR_CTRL_RR 0
`define CCR_CTRL_RIE 1
`define CCR_CTRL_TIE 2
`define CCR_CTRL_EIE 3
`define CCR_CTRL_OIE 4
`define CCR_CTRL_ONE 5
`define CCR_CTRL_SPARE 6
`define CCR_CTRL_ZERO 7
`define CCR_CMD_SEND 0
`define CCR_CMD_CANCEL 1
`define CCR_CMD_FREE 2
`define CCR_CMD_CLROVR 3
`define CCR_CMD_SLEEP 4
`define CCR_CMD_READ 8'hFF
`define CCR_FREE_BITS 4'hB
`define CCR_FREE_SHORT 8'h01
`define CCR_FREE_LONG 8'h80
`define CCR_FIFO_HW_START 6'h00
`endif

/* hdl/ccr_pkg.sv */
// types of the can controller control-register block
package ccr_pkg;
   typedef enum logic [1:0] {CCR_RESET_MODE, CCR_WAIT_FREE, CCR_OPERATING} ccr_mode_t;
endpackage

/* hdl/ccr_free_if.sv */
// link between mode control and bus-free counter
`timescale 1ns/100ps
`default_nettype none
interface ccr_free_if;
   logic bit_tick;
   logic bit_recessive;
   logic start;
   logic need_long;
   logic done;
   modport ctl (output bit_tick, output bit_recessive, output start, output need_long,
      input done);
   modport cnt (input bit_tick, input bit_recessive, input start, input need_long,
      output done);
endinterface
`default_nettype wire

/* hdl/ccr_free_counter.sv */
// counts bus-free sequences of eleven recessive bits
`include "ccr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ccr_free_counter
   import ccr_pkg::*;
(
   input wire logic ref_clk_in, // block clock
   input wire logic rst_n_in, // async reset, active low
   ccr_free_if.cnt fr // control side
);
   logic [3:0] run;
   logic [7:0] seen;
   logic armed;
   logic done_q;
   wire run_full = (run == `CCR_FREE_BITS - 4'h1) && fr.bit_tick && fr.bit_recessive;
   wire [7:0] target = fr.need_long ? `CCR_FREE_LONG : `CCR_FREE_SHORT;
   wire last_free = run_full && (seen == target - 8'h01);
   assign fr.done = done_q;
   // recessive run length, restarted by a dominant bit or a finished sequence
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run <= 4'h0;
      end else if (fr.start || run_full || (fr.bit_tick && !fr.bit_recessive)) begin
         run <= 4'h0;
      end else if (fr.bit_tick && armed) begin
         run <= run + 4'h1;
      end
   end
   // occurrences of bus-free and a one-cycle done pulse
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen <= 8'h00;
         armed <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= armed && last_free;
         if (fr.start) begin
            seen <= 8'h00;
            armed <= 1'b1;
         end else if (armed && last_free) begin
            armed <= 1'b0;
         end else if (armed && run_full) begin
            seen <= seen + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* hdl/ccr_control.sv */
// control register, command strobes and reset-mode sequencing over apb
//
// Local design decision: the APB interface to the registers.
`include "ccr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ccr_control
   import ccr_pkg::*;
(
   input wire logic ref_clk_in, // 40 mhz oscillator clock
   input wire logic rst_n_in, // hardware reset, async, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic bus_off_in, // bus status from error logic
   input wire logic error_status_in, // error status from error logic
   input wire logic rx_ok_in, // pulse: message received without error
   input wire logic tx_done_in, // pulse: message transmitted successfully
   input wire logic tx_buf_free_in, // level: transmit buffer accessible
   input wire logic overrun_in, // level: data overrun status
   input wire logic bit_tick_in, // pulse: one bit sampled on the bus
   input wire logic bit_recessive_in, // sampled bit is recessive
   input wire logic [5:0] fifo_start_in, // currently valid fifo start address
   output logic reset_mode_out, // controller held in reset mode, aborts traffic
   output logic bus_on_out, // controller takes part in bus activity
   output logic fifo_load_out, // pulse: load fifo pointers
   output logic [5:0] fifo_ptr_out, // value for fifo pointers
   output logic copy_tx_out, // pulse: copy sent message into receive area
   output logic rx_irq_out, // pulse: receive interrupt
   output logic tx_irq_out, // pulse: transmit interrupt
   output logic err_irq_out, // pulse: error interrupt
   output logic ovr_irq_out, // pulse: overrun interrupt
   output logic send_request_out, // pulse: transmission request
   output logic cancel_send_out, // pulse: abort transmission
   output logic free_receive_window_out, // pulse: release receive buffer
   output logic clear_overrun_flag_out, // pulse: clear data overrun
   output logic sleep_request_out // pulse: go to sleep
);
   ccr_free_if fr ();
   ccr_mode_t mode, next_mode;
   logic [4:0] ctrl_low; // enables and reset request
   logic spare_bit; // kept through every reset
   logic phase; // internal half-rate clock
   logic rr_pend, rr_pend_val;
   logic busoff_cause;
   logic bus_off_q, err_q, ovr_q, tbf_q;
   logic first_cycle;
   logic [4:0] cmd_q;
   logic [7:0] read_q;

   // apb decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire hit_ctrl = (paddr == `CCR_ADDR_CONTROL);
   wire hit_cmd = (paddr == `CCR_ADDR_COMMAND);
   wire hit_stat = (paddr == `CCR_ADDR_STATUS);
   wire mapped = hit_ctrl || hit_cmd || hit_stat;
   wire wr_ctrl = access && pwrite && hit_ctrl;
   wire wr_cmd = access && pwrite && hit_cmd;
   wire tick = phase; // falling edge of the divided clock
   wire rr = ctrl_low[`CCR_CTRL_RR];
   wire [7:0] ctrl_view = {1'b0, spare_bit, 1'b1, ctrl_low};
   wire [7:0] stat_view = {4'h0, busoff_cause, bus_on_out, reset_mode_out, rr_pend};
   wire [7:0] read_sel = hit_ctrl ? ctrl_view :
                         hit_cmd ? `CCR_CMD_READ :
                         hit_stat ? stat_view : 8'h00;
   wire bus_off_rise = bus_off_in && !bus_off_q;
   wire rr_set_sw = tick && rr_pend && rr_pend_val;
   wire rr_clr_sw = tick && rr_pend && !rr_pend_val;
   wire rr_fall = rr && rr_clr_sw && !bus_off_in;

   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = {24'h000000, read_q};
   assign reset_mode_out = rr;
   assign bus_on_out = (mode == CCR_OPERATING);

   // read data captured in the setup phase
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         read_q <= 8'h00;
      end else if (setup && !pwrite) begin
         read_q <= read_sel;
      end
   end

   // half-rate internal clock phase
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase <= 1'b0;
      end else begin
         phase <= !phase;
      end
   end

   // spare bit has no reset: only software changes it
   always_ff @(posedge ref_clk_in) begin
      if (wr_ctrl) begin
         spare_bit <= pwdata[`CCR_CTRL_SPARE];
      end
   end

   // interrupt enables take writes at once
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_low[4:1] <= 4'h0;
      end else if (wr_ctrl) begin
         ctrl_low[4:1] <= pwdata[`CCR_CTRL_OIE:`CCR_CTRL_RIE];
      end
   end

   // software reset request held until the divided clock edge
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rr_pend <= 1'b0;
         rr_pend_val <= 1'b0;
      end else if (wr_ctrl) begin
         rr_pend <= 1'b1;
         rr_pend_val <= pwdata[`CCR_CTRL_RR];
      end else if (tick) begin
         rr_pend <= 1'b0;
      end
   end

   // reset request: bus-off wins over a software clear
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_low[`CCR_CTRL_RR] <= 1'b1;
      end else if (bus_off_in) begin
         ctrl_low[`CCR_CTRL_RR] <= 1'b1;
      end else if (rr_set_sw) begin
         ctrl_low[`CCR_CTRL_RR] <= 1'b1;
      end else if (rr_clr_sw) begin
         ctrl_low[`CCR_CTRL_RR] <= 1'b0;
      end
   end

   // remembers whether the last reset came from bus-off
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busoff_cause <= 1'b0;
      end else if (bus_off_in && !rr) begin
         busoff_cause <= 1'b1;
      end else if (rr_set_sw && !rr) begin
         busoff_cause <= 1'b0;
      end
   end

   // fifo pointer load on entry into reset mode
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_cycle <= 1'b1;
         fifo_load_out <= 1'b0;
         fifo_ptr_out <= `CCR_FIFO_HW_START;
      end else begin
         first_cycle <= 1'b0;
         fifo_load_out <= first_cycle || ((bus_off_in || rr_set_sw) && !rr);
         fifo_ptr_out <= first_cycle ? `CCR_FIFO_HW_START : fifo_start_in;
      end
   end

   // mode sequencing and bus-free wait
   assign fr.bit_tick = bit_tick_in;
   assign fr.bit_recessive = bit_recessive_in;
   assign fr.start = rr_fall;
   assign fr.need_long = busoff_cause;
   always_comb begin
      next_mode = mode;
      case (mode)
         CCR_RESET_MODE: if (rr_fall) next_mode = CCR_WAIT_FREE;
         CCR_WAIT_FREE: if (rr) next_mode = CCR_RESET_MODE;
            else if (fr.done) next_mode = CCR_OPERATING;
         CCR_OPERATING: if (rr) next_mode = CCR_RESET_MODE;
         default: next_mode = CCR_RESET_MODE;
      endcase
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode <= CCR_RESET_MODE;
      end else begin
         mode <= next_mode;
      end
   end

   ccr_free_counter u_free (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .fr(fr)
   );

   // previous status levels for change detection
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_off_q <= 1'b0;
         err_q <= 1'b0;
         ovr_q <= 1'b0;
         tbf_q <= 1'b1;
      end else begin
         bus_off_q <= bus_off_in;
         err_q <= error_status_in;
         ovr_q <= overrun_in;
         tbf_q <= tx_buf_free_in;
      end
   end

   // gated interrupt pulses and the ungated transmit copy pulse
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_irq_out <= 1'b0;
         tx_irq_out <= 1'b0;
         err_irq_out <= 1'b0;
         ovr_irq_out <= 1'b0;
         copy_tx_out <= 1'b0;
      end else begin
         rx_irq_out <= ctrl_low[`CCR_CTRL_RIE] && rx_ok_in;
         tx_irq_out <= ctrl_low[`CCR_CTRL_TIE] && (tx_done_in || (tx_buf_free_in && !tbf_q));
         err_irq_out <= ctrl_low[`CCR_CTRL_EIE] &&
            ((bus_off_in != bus_off_q) || (error_status_in != err_q));
         ovr_irq_out <= ctrl_low[`CCR_CTRL_OIE] && overrun_in && !ovr_q;
         copy_tx_out <= tx_done_in;
      end
   end

   // command strobes, one cycle per write
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_q <= 5'h00;
      end else begin
         cmd_q <= wr_cmd ? pwdata[`CCR_CMD_SLEEP:`CCR_CMD_SEND] : 5'h00;
      end
   end
   assign send_request_out = cmd_q[`CCR_CMD_SEND];
   assign cancel_send_out = cmd_q[`CCR_CMD_CANCEL];
   assign free_receive_window_out = cmd_q[`CCR_CMD_FREE];
   assign clear_overrun_flag_out = cmd_q[`CCR_CMD_CLROVR];
   assign sleep_request_out = cmd_q[`CCR_CMD_SLEEP] && !rr;

   // checks
   property p_cmd_read;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      setup && !pwrite && hit_cmd |=> prdata[7:0] == 8'hFF;
   endproperty
   a_cmd_read: assert property (p_cmd_read) else $error("command read not all ones");
   property p_busoff_rr;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_off_in |=> rr;
   endproperty
   a_busoff_rr: assert property (p_busoff_rr) else $error("bus-off did not set request");
   property p_busoff_err;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_off_rise && ctrl_low[`CCR_CTRL_EIE] |=> err_irq_out;
   endproperty
   a_busoff_err: assert property (p_busoff_err) else $error("no error irq on bus-off");
   property p_ovr_once;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      overrun_in && ovr_q |=> !ovr_irq_out;
   endproperty
   a_ovr_once: assert property (p_ovr_once) else $error("repeated overrun irq");
   property p_rx_gate;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      rx_irq_out |-> $past(ctrl_low[`CCR_CTRL_RIE]) && $past(rx_ok_in);
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receive irq while disabled");
   property p_tx_nolock;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      tx_done_in && !rx_ok_in |=> copy_tx_out && !rx_irq_out;
   endproperty
   a_tx_nolock: assert property (p_tx_nolock) else $error("copy missing or rx irq");
   property p_rr_sync;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(rr) && !bus_off_in && !$past(bus_off_in) |-> $past(tick) && $past(rr_pend);
   endproperty
   a_rr_sync: assert property (p_rr_sync) else $error("request changed off the edge");
   property p_rr_mode;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      rr |=> !bus_on_out;
   endproperty
   a_rr_mode: assert property (p_rr_mode) else $error("bus-on during reset mode");
   property p_one_bit;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      setup && !pwrite && hit_ctrl |=> {prdata[7], prdata[5]} == 2'b01;
   endproperty
   a_one_bit: assert property (p_one_bit) else $error("fixed control bits wrong");
   property p_wait_free;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      mode == CCR_WAIT_FREE && !rr && !fr.done |=> mode == CCR_WAIT_FREE;
   endproperty
   a_wait_free: assert property (p_wait_free) else $error("bus-on without bus-free");
endmodule
`default_nettype wire

/* dv/ccr_host_model.sv */
// host microcontroller model that drives the apb register port
`include "ccr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ccr_host_model (
   input wire logic ref_clk_in, // block clock
   output logic psel, // apb select
   output logic penable, // apb access phase
   output logic pwrite, // apb direction
   output logic [7:0] paddr, // apb byte address
   output logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr // apb error
);
   // bus idle at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // one transfer: setup, access held until pready, then release; tmo flags a hang
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e, output logic tmo);
      logic [31:0] dd;
      int n;
      n = 0;
      dd = d;
      if (w && a == `CCR_ADDR_CONTROL)
         dd[7] = 1'b0;
      @(posedge ref_clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= dd;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 64);
      r = prdata;
      e = pslverr;
      tmo = (pready !== 1'b1);
      // release here; the next setup waits an edge, so commands never arrive together
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* dv/can_control_register_reset_logic_tb.sv */
// self-checking bench for the control register and reset-mode block
`include "ccr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module can_control_register_reset_logic_tb;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, sp;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, tmp;
   logic bus_off_in = 1'b0, error_status_in = 1'b0, rx_ok_in = 1'b0, tx_done_in = 1'b0;
   logic tx_buf_free_in = 1'b1, overrun_in = 1'b0, bit_tick_in = 1'b0, bit_recessive_in = 1'b0;
   logic [5:0] fifo_start_in = 6'h15, fifo_ptr_out, last_ptr;
   logic reset_mode_out, bus_on_out, fifo_load_out, copy_tx_out, rx_irq_out, tx_irq_out;
   logic err_irq_out, ovr_irq_out, send_request_out, cancel_send_out, free_receive_window_out;
   logic clear_overrun_flag_out, sleep_request_out;
   logic [3:0] en = 4'h0;
   logic [10:0] pv;
   int cnt [11] = '{default: 0};
   int exp_cnt [11] = '{default: 0};
   int error_cnt = 0, checked = 0, seed = 32'hb1a3;

   ccr_control i_dut (.ref_clk_in, .rst_n_in, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus_off_in, .error_status_in, .rx_ok_in, .tx_done_in,
      .tx_buf_free_in, .overrun_in, .bit_tick_in, .bit_recessive_in, .fifo_start_in,
      .reset_mode_out, .bus_on_out, .fifo_load_out, .fifo_ptr_out, .copy_tx_out, .rx_irq_out,
      .tx_irq_out, .err_irq_out, .ovr_irq_out, .send_request_out, .cancel_send_out,
      .free_receive_window_out, .clear_overrun_flag_out, .sleep_request_out);
   ccr_host_model i_host (.ref_clk_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);

   // pulse outputs gathered: irqs 0..3, commands 4..8, copy 9, pointer load 10
   assign pv = {fifo_load_out, copy_tx_out, sleep_request_out, clear_overrun_flag_out,
      free_receive_window_out, cancel_send_out, send_request_out, ovr_irq_out, err_irq_out,
      tx_irq_out, rx_irq_out};
   // count every pulse and keep the last loaded pointer
   always @(posedge ref_clk_in) begin
      for (int i = 0; i < 11; i++)
         if (pv[i] === 1'b1) cnt[i] <= cnt[i] + 1;
      if (fifo_load_out === 1'b1) last_ptr <= fifo_ptr_out;
   end
   // 40 mhz clock
   always #12.5 ref_clk_in = ~ref_clk_in;

   task automatic end_sim();
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic cmp_cnt();
      // let the pulse counters settle before they are read
      #1;
      for (int i = 0; i < 11; i++)
         check(32'(cnt[i]), 32'(exp_cnt[i]));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
      input logic xe);
      logic [31:0] r;
      logic e, t;
      i_host.xfer(a, 1'b0, 32'h0, r, e, t);
      check(32'(t), 32'h0);
      if (t === 1'b1) end_sim();
      check(r & m, x);
      check(32'(e), 32'(xe));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e, t;
      i_host.xfer(a, 1'b1, d, r, e, t);
      check(32'(t), 32'h0);
      if (t === 1'b1) end_sim();
   endtask
   // control register access with the bench's own copy of the writable bits
   task automatic wr_ctrl(input logic rr);
      wr(`CCR_ADDR_CONTROL, {24'h0, 1'b0, sp, 1'b0, en, rr});
   endtask
   task automatic rd_ctrl(input logic rr);
      rd(`CCR_ADDR_CONTROL, 32'hFF, {24'h0, 1'b0, sp, 1'b1, en, rr}, 1'b0);
   endtask
   task automatic ticks(input int n, input logic rec);
      repeat (n) begin
         @(posedge ref_clk_in);
         bit_tick_in <= 1'b1;
         bit_recessive_in <= rec;
         @(posedge ref_clk_in);
         bit_tick_in <= 1'b0;
      end
   endtask
   // bounded wait on mode (w=0) or bus-on (w=1)
   task automatic wait_for(input logic w, input logic v, input int lim);
      int n;
      n = 0;
      while ((w ? bus_on_out : reset_mode_out) !== v && n < lim) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      check(32'(w ? bus_on_out : reset_mode_out), 32'(v));
      if ((w ? bus_on_out : reset_mode_out) !== v) end_sim();
   endtask
   // clear the request, then feed bus-free runs; bus-on only after the last one
   task automatic leave_reset(input int runs);
      wr_ctrl(1'b0);
      wait_for(1'b0, 1'b0, 3);
      rd_ctrl(1'b0);
      ticks(6, 1'b1);
      ticks(1, 1'b0);
      ticks(11 * (runs - 1) + 10, 1'b1);
      repeat (3) @(posedge ref_clk_in);
      check(32'(bus_on_out), 32'h0);
      ticks(1, 1'b1);
      wait_for(1'b1, 1'b1, 4);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      exp_cnt[10] = 1;
      cmp_cnt();
      check(32'(last_ptr), 32'h0);
      check(32'({reset_mode_out, bus_on_out}), 32'h2);
      rd(`CCR_ADDR_CONTROL, 32'hA1, 32'h21, 1'b0);
      rd(8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
      sp = 1'b1;
      wr_ctrl(1'b1);
      leave_reset(1);
      // random enables against every interrupt cause except a bus-off change
      repeat (4) begin
         tmp = $random(seed);
         en = tmp[3:0];
         sp = tmp[4];
         wr_ctrl(1'b0);
         rd_ctrl(1'b0);
         @(posedge ref_clk_in);
         rx_ok_in <= 1'b1;
         tx_done_in <= 1'b1;
         tx_buf_free_in <= 1'b0;
         error_status_in <= ~error_status_in;
         overrun_in <= 1'b1;
         @(posedge ref_clk_in);
         rx_ok_in <= 1'b0;
         tx_done_in <= 1'b0;
         @(posedge ref_clk_in);
         tx_buf_free_in <= 1'b1;
         repeat (4) @(posedge ref_clk_in);
         overrun_in <= 1'b0;
         repeat (3) @(posedge ref_clk_in);
         for (int j = 0; j < 4; j++)
            exp_cnt[j] += en[j];
         exp_cnt[1] += en[1];
         exp_cnt[9]++;
         cmp_cnt();
      end
      // every command strobe, then the command location reads all ones
      for (int i = 0; i < 5; i++) begin
         wr(`CCR_ADDR_COMMAND, 32'(1 << i));
         exp_cnt[4 + i]++;
      end
      repeat (3) @(posedge ref_clk_in);
      cmp_cnt();
      rd(`CCR_ADDR_COMMAND, 32'hFFFFFFFF, 32'hFF, 1'b0);
      // software reset request loads the current fifo start
      tmp = $random(seed);
      @(posedge ref_clk_in);
      fifo_start_in <= tmp[5:0];
      wr_ctrl(1'b1);
      wait_for(1'b0, 1'b1, 3);
      // bus-on is a registered state and leaves one edge after the request rises
      @(posedge ref_clk_in);
      #1;
      check(32'(bus_on_out), 32'h0);
      exp_cnt[10]++;
      repeat (2) @(posedge ref_clk_in);
      cmp_cnt();
      check(32'(last_ptr), 32'(tmp[5:0]));
      leave_reset(1);
      // bus-off forces the request, blocks clearing, needs 128 bus-free runs
      en = 4'h4;
      wr_ctrl(1'b0);
      tmp = $random(seed);
      @(posedge ref_clk_in);
      fifo_start_in <= tmp[5:0];
      bus_off_in <= 1'b1;
      wait_for(1'b0, 1'b1, 3);
      wr_ctrl(1'b0);
      rd_ctrl(1'b1);
      @(posedge ref_clk_in);
      bus_off_in <= 1'b0;
      exp_cnt[2] += 2;
      exp_cnt[10]++;
      repeat (3) @(posedge ref_clk_in);
      cmp_cnt();
      check(32'(last_ptr), 32'(tmp[5:0]));
      leave_reset(128);
      // hardware reset mid-run with a clearing write attempted while it is held
      @(posedge ref_clk_in);
      fifo_start_in <= 6'h2A;
      rst_n_in <= 1'b0;
      wr_ctrl(1'b0);
      @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      exp_cnt[10]++;
      cmp_cnt();
      check(32'(last_ptr), 32'h0);
      rd(`CCR_ADDR_CONTROL, 32'hE1, {24'h0, 1'b0, sp, 1'b1, 5'h01}, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
